//--- rtl/lc_cluster.sv
// Logic cluster of four slices with pairwise shared register controls.
// Assumes configuration ports are static outside reset; inputs synchronous to sys_clk.
`timescale 1ns/100ps

module lc_cluster
  import lc_pkg::*;
#(
  parameter int unsigned NS = LC_SLICES
)
(
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  input  wire logic [NS*2*LC_TBL_BITS-1:0] cfg_table_init,
  input  wire logic [NS-1:0]               cfg_five,
  input  wire logic [NS-1:0]               cfg_ripple,
  input  wire logic                        cfg_ram_mode,
  input  wire logic [NS*LC_FFS-1:0]        cfg_direct,
  input  wire logic [NS*LC_FFS-1:0]        cfg_init_set,
  input  wire logic [NS*LC_FFS-1:0]        cfg_negedge,
  input  wire logic [NS-1:0]               cfg_lsr_async,
  input  wire logic [NS*LC_TBL_IN-1:0]     table0_inputs,
  input  wire logic [NS*LC_TBL_IN-1:0]     table1_inputs,
  input  wire logic [NS-1:0]               five_select,
  input  wire logic [NS*LC_FFS-1:0]        direct_ff_inputs,
  input  wire logic [LC_PAIRS-1:0]         slice_clock,
  input  wire logic [LC_PAIRS-1:0]         pair_clock_enable,
  input  wire logic [LC_PAIRS-1:0]         local_set_reset,
  input  wire logic                        fast_carry_in,
  output logic      [NS-1:0]               comb_out_first,
  output logic      [NS-1:0]               comb_out_second,
  output logic      [NS*LC_FFS-1:0]        register_outputs,
  output logic                             fast_carry_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic [LC_PAIRS-1:0]     sclk_q;
  logic [LC_PAIRS-1:0]     rise;
  logic [LC_PAIRS-1:0]     fall;
  logic [NS:0]             chain;
  logic [NS-1:0]           f0_w;
  logic [NS-1:0]           f1_w;
  logic [NS-1:0]           f0_d;
  logic [NS-1:0]           f1_d;
  logic                    ram_we;
  logic [LC_TBL_IN-1:0]    ram_addr;

  // Slice clock is sampled, so its edges are single-cycle pulses
  assign rise = slice_clock & ~sclk_q;
  assign fall = ~slice_clock & sclk_q;
  assign chain[0] = fast_carry_in;

  // control slice supplies address and write enable
  assign ram_addr = table0_inputs[LC_RAM_CTRL*LC_TBL_IN +: LC_TBL_IN];
  assign ram_we   = cfg_ram_mode & direct_ff_inputs[LC_RAM_CTRL*LC_FFS + LC_WE_BIT];

  // four slices on routing and carry
  for (genvar s = 0; s < NS; s++) begin : g_slice
    localparam int unsigned P = s / (LC_SLICES / LC_PAIRS);
    logic [LC_FFS-1:0] edge_w;
    logic              store;
    assign edge_w = (cfg_negedge[s*LC_FFS +: LC_FFS] & {LC_FFS{fall[P]}})
                  | (~cfg_negedge[s*LC_FFS +: LC_FFS] & {LC_FFS{rise[P]}});
    // only the storage slices take writes
    assign store  = (s == LC_RAM_LO) || (s == LC_RAM_HI);
    lc_slice u_slice (
      .sys_clk          (sys_clk),
      .sys_rst          (sys_rst),
      .cfg_table_init   (cfg_table_init[s*2*LC_TBL_BITS +: 2*LC_TBL_BITS]),
      .cfg_five         (cfg_five[s]),
      .cfg_ripple       (cfg_ripple[s]),
      .cfg_direct       (cfg_direct[s*LC_FFS +: LC_FFS]),
      .cfg_init_set     (cfg_init_set[s*LC_FFS +: LC_FFS]),
      .cfg_lsr_async    (cfg_lsr_async[s]),
      .table0_inputs    (store && cfg_ram_mode ? ram_addr
                                               : table0_inputs[s*LC_TBL_IN +: LC_TBL_IN]),
      .table1_inputs    (store && cfg_ram_mode ? ram_addr
                                               : table1_inputs[s*LC_TBL_IN +: LC_TBL_IN]),
      .five_select      (five_select[s]),
      .direct_ff_inputs (direct_ff_inputs[s*LC_FFS +: LC_FFS]),
      .carry_in         (chain[s]),
      .wr_en            (store && ram_we),
      .wr_addr          (ram_addr),
      .wr_data          (direct_ff_inputs[s*LC_FFS +: LC_FFS]),
      .ff_edge          (edge_w),
      .ff_ce            (pair_clock_enable[P]),
      .local_set_reset  (local_set_reset[P]),
      .comb_first       (f0_w[s]),
      .comb_second      (f1_w[s]),
      .carry_out        (chain[s+1]),
      .register_outputs (register_outputs[s*LC_FFS +: LC_FFS])
    );
    // consumed slice shows zero on its comb outputs in memory mode; its registers still show
    assign f0_d[s] = (cfg_ram_mode && s == LC_RAM_CTRL) ? LC_ZERO : f0_w[s];
    assign f1_d[s] = (cfg_ram_mode && s == LC_RAM_CTRL) ? LC_ZERO : f1_w[s];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comb and carry outputs registered, costing one cycle of latency on those paths
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // Track the pin in reset too, so a high idle level gives no false edge
      sclk_q          <= slice_clock;
      comb_out_first  <= '0;
      comb_out_second <= '0;
      fast_carry_out  <= LC_ZERO;
    end else begin
      sclk_q          <= slice_clock;
      comb_out_first  <= f0_d;
      comb_out_second <= f1_d;
      // carry leaves toward the next cluster
      fast_carry_out  <= chain[NS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_ctrl_slice_quiet;
    @(posedge sys_clk) disable iff (sys_rst)
      cfg_ram_mode |=> !comb_out_first[LC_RAM_CTRL] && !comb_out_second[LC_RAM_CTRL];
  endproperty
  a_ctrl_slice_quiet: assert property (p_ctrl_slice_quiet) else $error("slice 2 active");

  property p_carry_pass;
    @(posedge sys_clk) disable iff (sys_rst)
      (cfg_ripple == '0) |=> fast_carry_out == $past(fast_carry_in);
  endproperty
  a_carry_pass: assert property (p_carry_pass) else $error("carry not passed");

  property p_five_sel;
    @(posedge sys_clk) disable iff (sys_rst)
      (cfg_five[3] && !cfg_ripple[3] && five_select[3])
      |=> comb_out_first[3] == comb_out_second[3];
  endproperty
  a_five_sel: assert property (p_five_sel) else $error("five-input select wrong");

  property p_five_low;
    @(posedge sys_clk) disable iff (sys_rst)
      (cfg_five[3] && !cfg_ripple[3] && !five_select[3])
      |=> comb_out_first[3] == $past(g_slice[3].u_slice.lut0);
  endproperty
  a_five_low: assert property (p_five_low) else $error("five-input low select wrong");

  property p_reset_quiet;
    @(posedge sys_clk)
      sys_rst |=> comb_out_first == '0 && comb_out_second == '0 && !fast_carry_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared");

  property p_sync_lsr_waits;
    @(posedge sys_clk) disable iff (sys_rst)
      (local_set_reset[0] && !cfg_lsr_async[1] && !rise[0] && !fall[0])
      |=> register_outputs[3:2] == $past(register_outputs[3:2]);
  endproperty
  a_sync_lsr_waits: assert property (p_sync_lsr_waits) else $error("sync set/reset too early");

  property p_fall_capture;
    @(posedge sys_clk) disable iff (sys_rst)
      (fall[1] && cfg_negedge[6] && pair_clock_enable[1] && !local_set_reset[1] && !cfg_direct[6])
      |=> register_outputs[6] == comb_out_first[3];
  endproperty
  a_fall_capture: assert property (p_fall_capture) else $error("falling capture wrong");

  property p_ctrl_tables_fixed;
    @(posedge sys_clk) disable iff (sys_rst)
      cfg_ram_mode |=> $stable(g_slice[LC_RAM_CTRL].u_slice.tbl0_q)
                       && $stable(g_slice[LC_RAM_CTRL].u_slice.tbl1_q);
  endproperty
  a_ctrl_tables_fixed: assert property (p_ctrl_tables_fixed) else $error("slice 2 written");

  property p_ram_write;
    @(posedge sys_clk) disable iff (sys_rst)
      ram_we |=> g_slice[LC_RAM_LO].u_slice.tbl0_q[$past(ram_addr)]
                 == $past(direct_ff_inputs[LC_RAM_LO*LC_FFS]);
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("memory write lost");

  property p_carry_generate;
    @(posedge sys_clk) disable iff (sys_rst)
      (cfg_ripple[NS-1] && table1_inputs[(NS-1)*LC_TBL_IN + LC_IN_A]
       && table1_inputs[(NS-1)*LC_TBL_IN + LC_IN_B]) |=> fast_carry_out;
  endproperty
  a_carry_generate: assert property (p_carry_generate) else $error("carry not generated");

  property p_pair_shared;
    @(posedge sys_clk) disable iff (sys_rst)
      (!pair_clock_enable[0] && !local_set_reset[0]) [*2] |->
        register_outputs[3:0] == $past(register_outputs[3:0]);
  endproperty
  a_pair_shared: assert property (p_pair_shared) else $error("pair 0/1 not held");

  property p_edge_capture;
    @(posedge sys_clk) disable iff (sys_rst)
      (fall[1] && !cfg_negedge[6] && !local_set_reset[1] && !cfg_lsr_async[3])
      |=> register_outputs[6] == $past(register_outputs[6]);
  endproperty
  a_edge_capture: assert property (p_edge_capture) else $error("wrong capture edge");

endmodule : lc_cluster

//--- rtl/lc_pkg.sv
// Shared constants for the four-slice logic cluster and its slices.
// Assumes one system clock; all fabric inputs are synchronous to it.
package lc_pkg;

  localparam int unsigned LC_SLICES    = 4;
  localparam int unsigned LC_PAIRS     = 2;
  localparam int unsigned LC_TBL_IN    = 4;
  localparam int unsigned LC_TBL_BITS  = 16;
  localparam int unsigned LC_FFS       = 2;
  // Slice roles in distributed memory mode
  localparam int unsigned LC_RAM_LO    = 0;
  localparam int unsigned LC_RAM_HI    = 1;
  localparam int unsigned LC_RAM_CTRL  = 2;
  // Bit positions inside the two table inputs
  localparam int unsigned LC_IN_A      = 0;
  localparam int unsigned LC_IN_B      = 1;
  // Write enable travels on the direct input of the control slice
  localparam int unsigned LC_WE_BIT    = 0;
  localparam logic        LC_ZERO      = 1'h0;

  // Four-input table lookup
  function automatic logic lc_four_input_table(input logic [LC_TBL_BITS-1:0] tbl,
                                   input logic [LC_TBL_IN-1:0]   idx);
    lc_four_input_table = tbl[idx];
  endfunction : lc_four_input_table

  // Carry out of one ripple bit
  function automatic logic lc_carry(input logic g, input logic p, input logic ci);
    lc_carry = g | (p & ci);
  endfunction : lc_carry

endpackage : lc_pkg

//--- rtl/lc_slice.sv
// One slice: two four-input tables, ripple carry, table write port, two flip-flops.
// Assumes edge pulses and shared controls are prepared by the cluster.
`timescale 1ns/100ps

module lc_slice
  import lc_pkg::*;
(
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  input  wire logic [2*LC_TBL_BITS-1:0]      cfg_table_init,
  input  wire logic                          cfg_five,
  input  wire logic                          cfg_ripple,
  input  wire logic [LC_FFS-1:0]             cfg_direct,
  input  wire logic [LC_FFS-1:0]             cfg_init_set,
  input  wire logic                          cfg_lsr_async,
  input  wire logic [LC_TBL_IN-1:0]          table0_inputs,
  input  wire logic [LC_TBL_IN-1:0]          table1_inputs,
  input  wire logic                          five_select,
  input  wire logic [LC_FFS-1:0]             direct_ff_inputs,
  input  wire logic                          carry_in,
  input  wire logic                          wr_en,
  input  wire logic [LC_TBL_IN-1:0]          wr_addr,
  input  wire logic [LC_FFS-1:0]             wr_data,
  input  wire logic [LC_FFS-1:0]             ff_edge,
  input  wire logic                          ff_ce,
  input  wire logic                          local_set_reset,
  output logic                               comb_first,
  output logic                               comb_second,
  output logic                               carry_out,
  output logic      [LC_FFS-1:0]             register_outputs
);

  ////////////////////////////////////////////////////////////////////////////
  logic [LC_TBL_BITS-1:0] tbl0_q;
  logic [LC_TBL_BITS-1:0] tbl1_q;
  logic                   lut0;
  logic                   lut1;
  logic                   c_mid;
  logic                   gen0;
  logic                   gen1;
  logic [LC_FFS-1:0]      table_feed_inputs;
  logic [LC_FFS-1:0]      ff_data;
  logic [LC_FFS-1:0]      lsr_hit;
  logic [LC_FFS-1:0]      ff_d;

  assign lut0 = lc_four_input_table(tbl0_q, table0_inputs);
  assign lut1 = lc_four_input_table(tbl1_q, table1_inputs);
  assign gen0 = table0_inputs[LC_IN_A] & table0_inputs[LC_IN_B];
  assign gen1 = table1_inputs[LC_IN_A] & table1_inputs[LC_IN_B];
  assign c_mid = lc_carry(gen0, lut0, carry_in);
  assign carry_out = cfg_ripple ? lc_carry(gen1, lut1, c_mid) : carry_in;
  assign comb_first  = cfg_ripple ? (lut0 ^ carry_in)
                     : (cfg_five ? (five_select ? lut1 : lut0) : lut0);
  assign comb_second = cfg_ripple ? (lut1 ^ c_mid) : lut1;
  assign table_feed_inputs = {comb_second, comb_first};
  assign ff_data = (cfg_direct & direct_ff_inputs) | (~cfg_direct & table_feed_inputs);
  assign lsr_hit = {LC_FFS{local_set_reset}} & (cfg_lsr_async ? {LC_FFS{1'h1}} : ff_edge);
  assign ff_d = (lsr_hit & cfg_init_set) | (~lsr_hit & ((ff_edge & {LC_FFS{ff_ce}} & ff_data)
              | (~(ff_edge & {LC_FFS{ff_ce}}) & register_outputs)));

  ////////////////////////////////////////////////////////////////////////////
  // Table contents double as the distributed memory cells
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tbl0_q <= cfg_table_init[LC_TBL_BITS-1:0];
      tbl1_q <= cfg_table_init[2*LC_TBL_BITS-1:LC_TBL_BITS];
    end else if (wr_en) begin
      tbl0_q[wr_addr] <= wr_data[0];
      tbl1_q[wr_addr] <= wr_data[1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      register_outputs <= cfg_init_set;
    end else begin
      register_outputs <= ff_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_init_after_reset;
    @(posedge sys_clk) $past(sys_rst) |-> register_outputs == $past(cfg_init_set);
  endproperty
  a_init_after_reset: assert property (p_init_after_reset) else $error("bad start value");

  property p_hold_no_ce;
    @(posedge sys_clk) disable iff (sys_rst)
      (!ff_ce && !local_set_reset) |=> register_outputs == $past(register_outputs);
  endproperty
  a_hold_no_ce: assert property (p_hold_no_ce) else $error("register moved without enable");

  property p_lsr_wins;
    @(posedge sys_clk) disable iff (sys_rst)
      (local_set_reset && cfg_lsr_async) |=> register_outputs == $past(cfg_init_set);
  endproperty
  a_lsr_wins: assert property (p_lsr_wins) else $error("set/reset not applied");

  property p_direct_path;
    @(posedge sys_clk) disable iff (sys_rst)
      (!local_set_reset && ff_ce && ff_edge[0] && cfg_direct[0])
      |=> register_outputs[0] == $past(direct_ff_inputs[0]);
  endproperty
  a_direct_path: assert property (p_direct_path) else $error("direct input not captured");

  property p_second_four;
    @(posedge sys_clk) disable iff (sys_rst)
      !cfg_ripple |-> comb_second == tbl1_q[table1_inputs];
  endproperty
  a_second_four: assert property (p_second_four) else $error("second output wrong");

endmodule : lc_slice

//--- verification/lc_fabric_model.sv
// Fabric model: pair clock sources and the neighbour carry.
// Assumes requests are set up before the rising sys_clk edge.
`timescale 1ns/100ps

module lc_fabric_model (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] toggle_req,
  input  wire logic       carry_req,
  output logic      [1:0] slice_clock,
  output logic            fast_carry_in
);
  ////////////////////////////////////////////////////////////
  // one clock per pair
  // Each level lasts a full cycle so no sampled edge is lost
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      slice_clock <= 2'h0;
    end else begin
      slice_clock <= slice_clock ^ toggle_req;
    end
  end
  always_ff @(posedge sys_clk) begin
    fast_carry_in <= carry_req;
  end
endmodule : lc_fabric_model

//--- verification/logic_slice_cell_bench.sv
// Self-checking bench for the four-slice logic cluster.
// Assumes the fabric model supplies the pair clocks and carry in.
`timescale 1ns/100ps

module logic_slice_cell_bench;
  import lc_pkg::*;
  localparam logic [127:0] tbl_init = 128'h96e1_3c5a_0ff0_a53c_e817_6b2d_c3c3_5a69;
  logic         sys_clk = 1'h0;
  logic         sys_rst = 1'h1;
  logic         cfg_ram_mode = 1'h0;
  logic         carry_req = 1'h0;
  logic         fast_carry_in;
  logic         fast_carry_out;
  logic [1:0]   toggle_req = 2'h0;
  logic [1:0]   slice_clock;
  logic [1:0]   pair_clock_enable = 2'h3;
  logic [1:0]   local_set_reset = 2'h0;
  logic [3:0]   cfg_five = 4'h0;
  logic [3:0]   cfg_ripple = 4'h0;
  logic [3:0]   cfg_lsr_async = 4'h5;
  logic [3:0]   five_select = 4'h0;
  logic [3:0]   comb_out_first;
  logic [3:0]   comb_out_second;
  logic [3:0]   d;
  logic [7:0]   cfg_direct = 8'h00;
  logic [7:0]   cfg_init_set = 8'ha5;
  logic [7:0]   cfg_negedge = 8'h00;
  logic [7:0]   direct_ff_inputs = 8'h00;
  logic [7:0]   register_outputs;
  logic [7:0]   lv;
  logic [7:0]   lw;
  logic [15:0]  table0_inputs = 16'h0000;
  logic [15:0]  table1_inputs = 16'h0000;
  int           n_errors = 0;
  int           comparisons = 0;

  always #2.5 sys_clk = ~sys_clk;

  lc_cluster #(.NS(4)) dut (
    .sys_clk, .sys_rst, .cfg_table_init(tbl_init), .cfg_five, .cfg_ripple, .cfg_ram_mode,
    .cfg_direct, .cfg_init_set, .cfg_negedge, .cfg_lsr_async, .table0_inputs, .table1_inputs,
    .five_select, .direct_ff_inputs, .slice_clock, .pair_clock_enable, .local_set_reset,
    .fast_carry_in, .comb_out_first, .comb_out_second, .register_outputs, .fast_carry_out
  );

  lc_fabric_model fabric (
    .sys_clk, .sys_rst, .toggle_req, .carry_req, .slice_clock, .fast_carry_in
  );

  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic give_verdict;
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  function automatic logic tb(input int s, input int t, input logic [3:0] idx);
    return tbl_init[s*32 + t*16 + int'(idx)];
  endfunction : tb

  function automatic logic [7:0] luts;
    for (int s = 0; s < 4; s++) begin
      luts[2*s]   = tb(s, 0, table0_inputs[4*s +: 4]);
      luts[2*s+1] = tb(s, 1, table1_inputs[4*s +: 4]);
    end
  endfunction : luts

  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : step

  // Config is only legal to change while reset is held
  task automatic do_reset;
    sys_rst = 1'h1;
    step(4);
    sys_rst = 1'h0;
  endtask : do_reset

  task automatic tog(input logic [1:0] p);
    toggle_req = p;
    step(1);
    toggle_req = 2'h0;
    step(1);
  endtask : tog

  task automatic sweep;
    logic [3:0] e;
    logic [3:0] s1;
    for (int i = 0; i < 16; i++) begin
      table0_inputs = {4{i[3:0]}};
      table1_inputs = {4{~i[3:0]}};
      five_select = i[3:0] ^ 4'h6;
      step(1);
      for (int s = 0; s < 4; s++) begin
        e[s] = (cfg_five[s] & five_select[s]) ? tb(s, 1, ~i[3:0]) : tb(s, 0, i[3:0]);
        s1[s] = tb(s, 1, ~i[3:0]);
      end
      chk("first out", 8'(comb_out_first), 8'(e));
      chk("second out", 8'(comb_out_second), 8'(s1));
    end
  endtask : sweep

  ////////////////////////////////////////////////////////////
  initial begin
    step(4);
    chk("reset regs", register_outputs, 8'ha5);
    chk("reset comb", {comb_out_second, comb_out_first}, 8'h00);
    sys_rst = 1'h0;
    sweep();
    cfg_five = 4'ha;
    do_reset();
    sweep();
    cfg_five = 4'h0;
    cfg_negedge = 8'hf0;
    do_reset();
    table0_inputs = 16'h3c96;
    table1_inputs = 16'h5a0f;
    step(1);
    lv = luts();
    tog(2'h1);
    chk("rise capture", register_outputs, {4'ha, lv[3:0]});
    tog(2'h2);
    chk("no capture on rise", register_outputs, {4'ha, lv[3:0]});
    tog(2'h2);
    chk("fall capture", register_outputs, lv);
    table0_inputs = 16'h8e71;
    table1_inputs = 16'h2bd4;
    pair_clock_enable = 2'h2;
    step(1);
    lw = luts();
    tog(2'h3);
    tog(2'h3);
    chk("enable hold", register_outputs, {lw[7:4], lv[3:0]});
    pair_clock_enable = 2'h3;
    cfg_direct = 8'hff;
    cfg_negedge = 8'h00;
    do_reset();
    direct_ff_inputs = 8'h3c;
    tog(2'h3);
    chk("direct capture", register_outputs, 8'h3c);
    local_set_reset = 2'h1;
    step(2);
    chk("async set reset", register_outputs, 8'h3d);
    tog(2'h3);
    tog(2'h3);
    chk("set reset over enable", register_outputs, 8'h35);
    local_set_reset = 2'h0;
    cfg_direct = 8'h00;
    cfg_ripple = 4'hf;
    do_reset();
    carry_req = 1'h1;
    table0_inputs = 16'h3333;
    table1_inputs = 16'h3333;
    step(2);
    lv = luts();
    chk("ripple sum", {comb_out_second, comb_out_first}, ~{lv[7], lv[5], lv[3], lv[1],
        lv[6], lv[4], lv[2], lv[0]});
    chk("carry out", 8'(fast_carry_out), 8'h01);
    carry_req = 1'h0;
    table0_inputs = 16'h0000;
    table1_inputs = 16'h0000;
    step(2);
    chk("carry out low", 8'(fast_carry_out), 8'h00);
    cfg_ripple = 4'h0;
    cfg_ram_mode = 1'h1;
    do_reset();
    table0_inputs = 16'h9000;
    for (int a = 0; a < 16; a++) begin
      table0_inputs[11:8] = a[3:0];
      direct_ff_inputs = {3'h0, 1'h1, a[3:0] ^ 4'h9};
      step(1);
    end
    direct_ff_inputs = 8'h00;
    for (int a = 0; a < 16; a++) begin
      table0_inputs[11:8] = a[3:0];
      d = a[3:0] ^ 4'h9;
      step(1);
      chk("ram read", {comb_out_second, comb_out_first}, {tb(3, 1, 4'h0), 1'h0, d[3], d[1],
          tb(3, 0, 4'h9), 1'h0, d[2], d[0]});
    end
    give_verdict();
  end

  // Watchdog against a hung sequence
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end
endmodule : logic_slice_cell_bench
